// ### hdl/write_ring_protect.sv
// Write-ring protect logic with AXI4-Lite register access
//
// Overview of operation
// - Load not pressed: latch clear, lockout, solenoid off
// - Grounded ring switch never sets the latch
// - Latch sets only while tape still unloaded
// - Latch sets only after load request drops
// - After loading, ring changes leave latch alone
// - Latch set releases lockout, lights write lamp
// - Solenoid driver follows the write-permit latch
// - Grounded ring switch forces head drives off
// - Head drives need ring open and write-ready
// - Fault when both markers seen or load requested
// - Fault indication starts high after power-up
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module write_ring_protect
(
  input wire logic clock,
  input wire logic rst_b,
  // Transport pins
  input wire logic ring_open_in,
  input wire logic load_pressed_in,
  input wire logic load_request_in,
  input wire logic beginning_marker_seen,
  input wire logic end_marker_seen,
  input wire logic write_ready_in,
  output logic tape_fault_unloaded,
  output logic write_lockout_n,
  output logic write_lamp,
  output logic solenoid_drive,
  output logic write_head_en,
  output logic erase_head_en,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [write_protect_pkg::SYNC_W-1:0] pins_async;
  logic [write_protect_pkg::SYNC_W-1:0] pins_sync;
  logic fault_reg;
  logic permit;
  logic permit_d_reg;
  logic lockout_n_reg;
  logic lamp_reg;
  logic solenoid_reg;
  logic heads_reg;
  logic ctrl_force_reg;
  logic [write_protect_pkg::IRQ_W-1:0] irq_status_reg;
  logic [write_protect_pkg::IRQ_W-1:0] irq_status_next;
  logic [write_protect_pkg::IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic [3:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic fault_d_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Every pin is asynchronous to the clock, so all take two stages; lanes in package order
  assign pins_async = {write_ready_in, end_marker_seen, beginning_marker_seen,
                       load_request_in, load_pressed_in, ring_open_in};

  bit_sync #(.WIDTH(write_protect_pkg::SYNC_W), .RESET_VALUE(write_protect_pkg::SYNC_RESET)) u_sync
  (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  wire ring_s = pins_sync[write_protect_pkg::SYNC_RING];
  wire load_pressed_s = pins_sync[write_protect_pkg::SYNC_LOAD_PRESSED];
  wire load_request_s = pins_sync[write_protect_pkg::SYNC_LOAD_REQUEST];
  wire begin_s = pins_sync[write_protect_pkg::SYNC_BEGIN];
  wire end_s = pins_sync[write_protect_pkg::SYNC_END];
  wire write_ready_s = pins_sync[write_protect_pkg::SYNC_WRITE_READY];

  ////////////////////////////////////////////////////////////////////////
  // Tape-fault indication

  // Both markers at once means no tape across the sensors
  wire fault_next = (begin_s && end_s) || load_request_s;

  // Starts high so the load control is preset until the pins settle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      fault_reg <= write_protect_pkg::FAULT_RESET;
    else
      fault_reg <= fault_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-permit latch and pin drivers

  permit_latch u_latch
  (
    .clock(clock),
    .rst_b(rst_b),
    .ring_open(ring_s),
    .load_pressed(load_pressed_s),
    .load_request(load_request_s),
    .fault(fault_reg),
    .force_protect(ctrl_force_reg),
    .permit(permit)
  );

  // Heads depend on the switch itself, not the latch, so a grounded
  // switch cuts them at once even while the latch still holds
  wire heads_next = ring_s && write_ready_s;

  // Drivers are registered copies: one clock behind the latch, the heads one clock behind heads_next
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lockout_n_reg <= write_protect_pkg::LOCKOUT_N_RESET;
      lamp_reg <= 1'b0;
      solenoid_reg <= 1'b0;
      heads_reg <= 1'b0;
    end
    else
    begin
      lockout_n_reg <= permit;
      lamp_reg <= permit;
      solenoid_reg <= permit;
      heads_reg <= heads_next;
    end
  end

  assign tape_fault_unloaded = fault_reg;
  assign write_lockout_n = lockout_n_reg;
  assign write_lamp = lamp_reg;
  assign solenoid_drive = solenoid_reg;
  assign write_head_en = heads_reg;
  assign erase_head_en = heads_reg;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  // Address and data are captured separately, in either order
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_ctrl = do_write && (aw_addr_reg == write_protect_pkg::CTRL_OFFSET);
  wire wr_irq_status = do_write && (aw_addr_reg == write_protect_pkg::IRQ_STATUS_OFFSET);
  wire wr_irq_mask = do_write && (aw_addr_reg == write_protect_pkg::IRQ_MASK_OFFSET);
  wire wr_hit = wr_ctrl || wr_irq_status || wr_irq_mask || (aw_addr_reg == write_protect_pkg::STATUS_OFFSET);

  // Hold captured halves until both are in and the write is carried out
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (w_take)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  // Upper address bits are ignored, so the map aliases every 16 bytes
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= write_protect_pkg::RESP_OKAY;
    end
    else
    begin
      awready_reg <= !aw_held_reg && !aw_take && !bvalid_reg;
      wready_reg <= !w_held_reg && !w_take && !bvalid_reg;
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? write_protect_pkg::RESP_OKAY : write_protect_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Software protect bit in byte lane 0
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_force_reg <= write_protect_pkg::CTRL_RESET[write_protect_pkg::CTRL_FORCE_PROTECT_BIT];
    else if (wr_ctrl && w_strb_reg[0])
      ctrl_force_reg <= w_data_reg[write_protect_pkg::CTRL_FORCE_PROTECT_BIT];
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  wire ar_take = s_axi_arvalid && arready_reg;
  wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
  wire rd_hit = (rd_addr == write_protect_pkg::CTRL_OFFSET) ||
                  (rd_addr == write_protect_pkg::STATUS_OFFSET) ||
                  (rd_addr == write_protect_pkg::IRQ_STATUS_OFFSET) ||
                  (rd_addr == write_protect_pkg::IRQ_MASK_OFFSET);
  wire [31:0] status_word = {25'h0, heads_reg, write_ready_s, load_request_s,
                        load_pressed_s, fault_reg, ring_s, permit};
  wire [31:0] rd_word = (rd_addr == write_protect_pkg::CTRL_OFFSET) ? {31'h0, ctrl_force_reg} :
                   (rd_addr == write_protect_pkg::STATUS_OFFSET) ? status_word :
                   (rd_addr == write_protect_pkg::IRQ_STATUS_OFFSET) ? {29'h0, irq_status_reg} :
                   (rd_addr == write_protect_pkg::IRQ_MASK_OFFSET) ? {29'h0, irq_mask_reg} :
                   32'h0000_0000;

  // One read in flight; data is captured when the address is taken
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= write_protect_pkg::RESP_OKAY;
    end
    else
    begin
      arready_reg <= !rvalid_reg && !ar_take;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? write_protect_pkg::RESP_OKAY : write_protect_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Events: latch set, latch cleared, fault indication rising
  wire [write_protect_pkg::IRQ_W-1:0] irq_events = {fault_reg && !fault_d_reg, !permit && permit_d_reg,
                                                    permit && !permit_d_reg};
  wire [write_protect_pkg::IRQ_W-1:0] irq_w1c = wr_irq_status && w_strb_reg[0] ?
                   w_data_reg[write_protect_pkg::IRQ_W-1:0] :
                   {write_protect_pkg::IRQ_W{1'b0}};
  // A new event in the clearing cycle survives the clear
  assign irq_status_next = (irq_status_reg & ~irq_w1c) | irq_events;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      permit_d_reg <= 1'b0;
      fault_d_reg <= write_protect_pkg::FAULT_RESET;
      irq_status_reg <= {write_protect_pkg::IRQ_W{1'b0}};
      irq_mask_reg <= write_protect_pkg::IRQ_MASK_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      permit_d_reg <= permit;
      fault_d_reg <= fault_reg;
      irq_status_reg <= irq_status_next;
      if (wr_irq_mask && w_strb_reg[0])
        irq_mask_reg <= w_data_reg[write_protect_pkg::IRQ_W-1:0];
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_unpressed_clears: assert property (!load_pressed_s |=> !permit ##1 !solenoid_drive)
    else $error("latch or solenoid active without load press");
  a_ground_no_set: assert property (!ring_s && !permit |=> !permit)
    else $error("latch set with ring switch grounded");
  a_set_needs_fault: assert property ($rose(permit) |-> $past(fault_reg))
    else $error("latch set after tape loaded");
  a_set_after_release: assert property ($rose(permit) |-> !$past(load_request_s))
    else $error("latch set while load request active");
  a_loaded_holds: assert property (permit && !fault_reg && load_pressed_s && !ctrl_force_reg |=> permit)
    else $error("latch changed after loading");
  a_lockout_lamp: assert property (permit |=> write_lockout_n && write_lamp)
    else $error("lockout or lamp not following latch");
  a_solenoid_follow: assert property (solenoid_drive == $past(permit))
    else $error("solenoid not following latch");
  a_heads_grounded: assert property (!ring_s |=> !write_head_en && !erase_head_en)
    else $error("head drive with ring grounded");
  a_heads_enable: assert property (ring_s && write_ready_s |=> write_head_en && erase_head_en)
    else $error("head drive missing with ring open and ready");
  a_fault_source: assert property (load_request_s || (begin_s && end_s) |=> tape_fault_unloaded)
    else $error("fault indication missing");
  a_sync_depth: assert property (ring_s == $past(ring_open_in, 2))
    else $error("ring switch not two stages deep");
  a_write_response: assert property (aw_held_reg && w_held_reg && !bvalid_reg |=> s_axi_bvalid)
    else $error("write response late");
  a_irq_level: assert property ((|(irq_status_reg & irq_mask_reg)) && !wr_irq_status |=> irq)
    else $error("interrupt output wrong");

  c_permit_set: cover property ($rose(permit));
  c_heads_on: cover property ($rose(write_head_en));
  c_irq_raised: cover property ($rose(irq));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);

endmodule : write_ring_protect

// ### include/write_protect_pkg.sv
// Constants shared by the write-ring protect block
package write_protect_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'hc;
  // Control fields
  localparam int CTRL_FORCE_PROTECT_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status fields
  localparam int STATUS_PERMIT_BIT = 0;
  localparam int STATUS_RING_OPEN_BIT = 1;
  localparam int STATUS_FAULT_BIT = 2;
  localparam int STATUS_LOAD_PRESSED_BIT = 3;
  localparam int STATUS_LOAD_REQUEST_BIT = 4;
  localparam int STATUS_WRITE_READY_BIT = 5;
  localparam int STATUS_HEADS_BIT = 6;
  // Interrupt fields, same layout in status and mask
  localparam int IRQ_W = 3;
  localparam int IRQ_PERMIT_SET_BIT = 0;
  localparam int IRQ_PERMIT_CLEAR_BIT = 1;
  localparam int IRQ_FAULT_RISE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  // Synchroniser lanes
  localparam int SYNC_W = 6;
  localparam int SYNC_RING = 0;
  localparam int SYNC_LOAD_PRESSED = 1;
  localparam int SYNC_LOAD_REQUEST = 2;
  localparam int SYNC_BEGIN = 3;
  localparam int SYNC_END = 4;
  localparam int SYNC_WRITE_READY = 5;
  // Load request lane resets high, so the fault line cannot dip while the stages flush
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h04;
  // Reset values of pin-facing state
  localparam logic FAULT_RESET = 1'b1;
  localparam logic LOCKOUT_N_RESET = 1'b0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : write_protect_pkg

// ### hdl/bit_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module bit_sync
#(
  parameter int WIDTH = write_protect_pkg::SYNC_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second; nothing else may look at it
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_lane
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_reg[i] <= RESET_VALUE[i];
          sync_out[i] <= RESET_VALUE[i];
        end
        else
        begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : bit_sync

// ### hdl/permit_latch.sv
// Write-permit latch: armed only while the reel is first loaded
`timescale 1ns/100ps
module permit_latch
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ring_open,
  input wire logic load_pressed,
  input wire logic load_request,
  input wire logic fault,
  input wire logic force_protect,
  output logic permit
);
  typedef enum logic {PROTECTED, PERMITTED} permit_state_t;
  permit_state_t state_reg;
  permit_state_t state_next;
  wire set_cond;
  wire clear_cond;

  // Set only with ring present, tape still unloaded and load released
  assign set_cond = ring_open && fault && !load_request;
  // Clear dominates: unpressed load button or software protect
  assign clear_cond = !load_pressed || force_protect;

  // Once loaded the fault line is low, so ring changes cannot reach the latch
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PROTECTED:
      begin
        if (!clear_cond && set_cond)
          state_next = PERMITTED;
      end
      PERMITTED:
      begin
        if (clear_cond)
          state_next = PROTECTED;
      end
      default:
      begin
        state_next = PROTECTED;
      end
    endcase
  end

  // Reset leaves the transport protected
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= PROTECTED;
    else
      state_reg <= state_next;
  end

  assign permit = (state_reg == PERMITTED);
endmodule : permit_latch

// ### verif/transport_model.sv
// Behavioural transport and controller model driving the write-ring pins
`timescale 1ns/100ps
module transport_model
#(
  parameter int THREAD = 20
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic press,
  input wire logic ring,
  input wire logic wr_rdy,
  output logic ring_open_in,
  output logic load_pressed_in,
  output logic load_request_in,
  output logic beginning_marker_seen,
  output logic end_marker_seen,
  output logic write_ready_in
);
  logic [7:0] cnt_reg;

  // Threading count: request phase, then bare-path phase, then parked
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      cnt_reg <= 8'h00;
    else if (!press)
      cnt_reg <= 8'h00;
    else if (cnt_reg < 8'(2 * THREAD))
      cnt_reg <= cnt_reg + 8'h01;
  end

  // Pins move just after an edge, as the real card's flops would
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ring_open_in <= 1'b0;
      load_pressed_in <= 1'b0;
      load_request_in <= 1'b1;
      beginning_marker_seen <= 1'b1;
      end_marker_seen <= 1'b1;
      write_ready_in <= 1'b0;
    end
    else
    begin
      ring_open_in <= ring;
      load_pressed_in <= press;
      load_request_in <= (cnt_reg < 8'(THREAD)); // Unloaded until threaded
      end_marker_seen <= (cnt_reg < 8'(2 * THREAD)); // Bare path lights both sensors
      beginning_marker_seen <= 1'b1; // Parked on the load point once loaded
      write_ready_in <= wr_rdy; // Controller raises it to record
    end
  end
endmodule : transport_model

// ### verif/tb_top.sv
// Self-checking bench for the write-ring protect block
`timescale 1ns/100ps
module tb_top;
  localparam int T = 20;
  localparam logic [7:0] ctl_a = 8'(write_protect_pkg::CTRL_OFFSET);
  localparam logic [7:0] sta_a = 8'(write_protect_pkg::STATUS_OFFSET);
  localparam logic [7:0] ist_a = 8'(write_protect_pkg::IRQ_STATUS_OFFSET);
  localparam logic [7:0] msk_a = 8'(write_protect_pkg::IRQ_MASK_OFFSET);
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic press = 1'b0;
  logic ring = 1'b0;
  logic wr_rdy = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic ring_open_in, load_pressed_in, load_request_in, beginning_marker_seen;
  logic end_marker_seen, write_ready_in, tape_fault_unloaded, write_lockout_n;
  logic write_lamp, solenoid_drive, write_head_en, erase_head_en, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] exp_q[$];

  ////////////////////////////////////////
  // Slow partner so the latch window is well away from the sync delay
  transport_model #(.THREAD(T)) transport_u (.clock, .rst_b, .press, .ring, .wr_rdy,
    .ring_open_in, .load_pressed_in, .load_request_in, .beginning_marker_seen,
    .end_marker_seen, .write_ready_in);

  write_ring_protect dut_u (.clock, .rst_b, .ring_open_in, .load_pressed_in,
    .load_request_in, .beginning_marker_seen, .end_marker_seen, .write_ready_in,
    .tape_fault_unloaded, .write_lockout_n, .write_lamp, .solenoid_drive, .write_head_en,
    .erase_head_en, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Every bus wait is bounded so a dead handshake ends the run
  task automatic hang(inout int n);
    n++;
    if (n > 50)
    begin
      fails++;
      $display("Error handshake expected answer seen none");
      wrap_up();
    end
  endtask : hang

  // Leading edge keeps a new request off the edge that closed the last one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      hang(n);
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(write_protect_pkg::RESP_OKAY), 32'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clock);
    exp_q.push_back(e);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      hang(n);
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Read data is matched against the oldest note when it is taken
  always @(posedge clock)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
    begin
      cmp("rresp", 32'(write_protect_pkg::RESP_OKAY), 32'(s_axi_rresp));
      cmp("rdata", exp_q.pop_front(), s_axi_rdata);
    end
  end

  task automatic pins(input logic l, input logic s, input logic h);
    cmp("lockout", l, write_lockout_n);
    cmp("lamp", l, write_lamp);
    cmp("solenoid", s, solenoid_drive);
    cmp("write head", h, write_head_en);
    cmp("erase head", h, erase_head_en);
  endtask : pins

  // Pin-to-output path is five cycles at most; eight leaves margin
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask : settle

  task automatic load(input logic r);
    @(posedge clock);
    ring <= r;
    press <= 1'b1;
    repeat (T) @(posedge clock);
    cmp("mid lockout", 1'b0, write_lockout_n);
    cmp("mid fault", 1'b1, tape_fault_unloaded);
    repeat (T + 10) @(posedge clock);
  endtask : load

  function automatic logic [31:0] st(input logic p, r, f, lp, lr);
    st = 32'h0;
    st[write_protect_pkg::STATUS_PERMIT_BIT] = p;
    st[write_protect_pkg::STATUS_RING_OPEN_BIT] = r;
    st[write_protect_pkg::STATUS_FAULT_BIT] = f;
    st[write_protect_pkg::STATUS_LOAD_PRESSED_BIT] = lp;
    st[write_protect_pkg::STATUS_LOAD_REQUEST_BIT] = lr;
  endfunction : st

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [2:0] m;
    logic w;
    logic prev;
    int i;
    void'($urandom(32'heaf5ae8f));
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    pins(1'b0, 1'b0, 1'b0);
    cmp("fault", 1'b1, tape_fault_unloaded);
    ring <= 1'b1;
    settle();
    pins(1'b0, 1'b0, 1'b0);
    cmp("fault", 1'b1, tape_fault_unloaded);
    rd(ctl_a, 32'h0);
    rd(msk_a, 32'h0);
    m = 3'($urandom);
    wr(msk_a, {29'h0, m});
    rd(msk_a, {29'h0, m});
    rd(msk_a + 8'h10, {29'h0, m});
    wr(sta_a, 32'hffff_ffff);
    rd(sta_a, st(1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
    // Reel without a ring, then ring opened too late to count
    load(1'b0);
    pins(1'b0, 1'b0, 1'b0);
    wr_rdy <= 1'b1;
    settle();
    pins(1'b0, 1'b0, 1'b0);
    ring <= 1'b1;
    settle();
    pins(1'b0, 1'b0, 1'b1);
    press <= 1'b0;
    wr_rdy <= 1'b0;
    settle();
    wr(ist_a, 32'h7);
    wr(msk_a, 32'h1 << write_protect_pkg::IRQ_PERMIT_SET_BIT);
    cmp("irq", 1'b0, irq);
    // Reel with a ring loaded properly
    load(1'b1);
    pins(1'b1, 1'b1, 1'b0);
    cmp("irq", 1'b1, irq);
    cmp("fault", 1'b0, tape_fault_unloaded);
    rd(sta_a, st(1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
    rd(ist_a, 32'h1);
    wr(ist_a, 32'h1);
    repeat (3) @(posedge clock);
    cmp("irq", 1'b0, irq);
    w = 1'b0;
    for (i = 0; i < 6; i++)
    begin
      prev = write_head_en;
      w = 1'($urandom);
      @(posedge clock);
      wr_rdy <= w;
      repeat (3) @(posedge clock);
      #1;
      cmp("head latency", prev, write_head_en);
      settle();
      pins(1'b1, 1'b1, w);
    end
    @(posedge clock);
    ring <= 1'b0;
    settle();
    pins(1'b1, 1'b1, 1'b0);
    wr(ctl_a, 32'h1);
    settle();
    pins(1'b0, 1'b0, 1'b0);
    wr(ctl_a, 32'h0);
    ring <= 1'b1;
    settle();
    pins(1'b0, 1'b0, w);
    press <= 1'b0;
    settle();
    pins(1'b0, 1'b0, w);
    rd(ist_a, 32'h6);
    cmp("irq", 1'b0, irq);
    wrap_up();
  end
endmodule : tb_top
